// [hdl/srx_regs.svh]
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH
// register word addresses
`define SRX_A_STBY   8'h00
`define SRX_A_START  8'h04
`define SRX_A_STOP   8'h08
`define SRX_A_STAT   8'h0c
`define SRX_A_DATA   8'h10
`define SRX_A_ERR    8'h14
`define SRX_A_ISTAT  8'h18
`define SRX_A_ICLR   8'h1c
`define SRX_A_IEN    8'h20
// field positions
`define SRX_STBY_WAKE  0
`define SRX_STBY_ESTOP 1
`define SRX_TRIG_CH0   0
`define SRX_ERR_FRM    0
`define SRX_ERR_PAR    1
`define SRX_ERR_OVR    2
`define SRX_IRQ_DONE   0
`define SRX_IRQ_ERR    1
`define SRX_DIV_LSB    9
`define SRX_DIV_MSB    15
// reset values
`define SRX_RST_STBY   2'h0
`define SRX_RST_DIV    7'h00
`endif

// [hdl/srx_pkg.sv]
package srx_pkg;
  typedef logic [7:0]  srx_addr_t;
  typedef logic [15:0] srx_word_t;
  // receive sequencer
  typedef enum logic [0:0] {
    SRX_WAIT = 1'b0,
    SRX_RECV = 1'b1
  } srx_state_t;
endpackage : srx_pkg

// [hdl/srx_channel.sv]
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "srx_regs.svh"
module srx_channel #(
  parameter int BITS = 8
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire srx_pkg::srx_addr_t i_addr,
  input  wire srx_pkg::srx_word_t i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output srx_pkg::srx_word_t      o_rdata,
  input  wire logic              i_sck,
  input  wire logic              i_si,
  input  wire logic              i_stop_mode,
  input  wire logic              i_false_start,
  input  wire logic              i_parity_err,
  input  wire logic              i_framing_err,
  output logic                   o_clock_request,
  output logic                   o_baud_adjust_en,
  output logic                   o_active,
  output logic                   o_irq
);
  import srx_pkg::*;

  // standby reset word and the widths of the flag groups
  localparam logic [1:0] RST_STBY = `SRX_RST_STBY;
  localparam int         ERR_W    = 3;
  localparam int         IRQ_W    = 2;

  // refuse lengths the data register or shifter cannot hold
  if (BITS < 2 || BITS > 9) begin : g_bits_check
    $error("BITS must be 2 to 9");
  end

  // reset release through two flops
  logic rst_s1_q;
  logic rst_b_q;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_q <= 1'b0;
      rst_b_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q  <= rst_s1_q;
    end
  end

  // pin synchronisers, two flops each
  // clock flops reset to the idle high level so no false edge follows
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_old_q;
  logic si_s1_q;
  logic si_s2_q;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sck_s1_q  <= 1'b1;
      sck_s2_q  <= 1'b1;
      sck_old_q <= 1'b1;
      si_s1_q   <= 1'b0;
      si_s2_q   <= 1'b0;
    end else begin
      sck_s1_q  <= i_sck;
      sck_s2_q  <= sck_s1_q;
      sck_old_q <= sck_s2_q;
      si_s1_q   <= i_si;
      si_s2_q   <= si_s1_q;
    end
  end

  // type 1 phase: data is taken on the rising clock edge
  logic sck_rise;
  assign sck_rise = sck_s2_q & ~sck_old_q;

  // address decode used by both strobes
  function automatic logic hit(input srx_addr_t a, input srx_addr_t r);
    hit = (a == r);
  endfunction : hit

  logic wr_stby;
  logic wr_start;
  logic wr_stop;
  logic wr_data;
  logic wr_err;
  logic wr_iclr;
  logic wr_ien;
  logic rd_data;
  assign wr_stby  = i_wr & hit(i_addr, `SRX_A_STBY);
  assign wr_start = i_wr & hit(i_addr, `SRX_A_START);
  assign wr_stop  = i_wr & hit(i_addr, `SRX_A_STOP);
  assign wr_data  = i_wr & hit(i_addr, `SRX_A_DATA);
  assign wr_err   = i_wr & hit(i_addr, `SRX_A_ERR);
  assign wr_iclr  = i_wr & hit(i_addr, `SRX_A_ICLR);
  assign wr_ien   = i_wr & hit(i_addr, `SRX_A_IEN);
  assign rd_data  = i_rd & hit(i_addr, `SRX_A_DATA);

  // one-shot triggers: only a written one acts
  logic start_pulse;
  logic stop_pulse;
  assign start_pulse = wr_start & i_wdata[`SRX_TRIG_CH0];
  assign stop_pulse  = wr_stop & i_wdata[`SRX_TRIG_CH0];

  // standby control: wake enable and error-stop select
  logic wake_en_q;
  logic err_stop_q;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      wake_en_q  <= RST_STBY[`SRX_STBY_WAKE];
      err_stop_q <= RST_STBY[`SRX_STBY_ESTOP];
    end else if (wr_stby) begin
      wake_en_q  <= i_wdata[`SRX_STBY_WAKE];
      err_stop_q <= i_wdata[`SRX_STBY_ESTOP];
    end
  end

  // wake bit going from one to zero
  logic wake_clear;
  assign wake_clear = wr_stby & wake_en_q & ~i_wdata[`SRX_STBY_WAKE];

  // channel active status, set by start and cleared by stop
  logic active_q;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      active_q <= 1'b0;
    end else if (start_pulse) begin
      active_q <= 1'b1;
    end else if (stop_pulse) begin
      active_q <= 1'b0;
    end
  end

  // reception may start while active, unless in stop mode without wake
  logic rx_allowed;
  assign rx_allowed = active_q & (~i_stop_mode | wake_en_q);

  // receive sequencer and shift register
  srx_state_t       state_q;
  logic [BITS-1:0]  shift_q;
  logic [3:0]       count_q;
  logic             done_pulse;
  logic [3:0]       last_cnt;
  assign last_cnt   = 4'(BITS - 1);
  assign done_pulse = rx_allowed & sck_rise &
                      (count_q == last_cnt);

  // stopping leaves shift data and bit count where they are
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      state_q <= SRX_WAIT;
    end else begin
      unique case (state_q)
        SRX_WAIT: begin
          // a character cut by a stop resumes at its saved count
          if (rx_allowed & sck_rise & (count_q != last_cnt)) begin
            state_q <= SRX_RECV;
          end
        end
        SRX_RECV: begin
          if (done_pulse | stop_pulse) begin
            state_q <= SRX_WAIT;
          end
        end
      endcase
    end
  end

  // msb first shift, one bit per rising clock while running
  // shift and count hold while inactive or blocked in stop mode
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      shift_q <= '0;
      count_q <= 4'h0;
    end else if (rx_allowed & sck_rise) begin
      shift_q <= {shift_q[BITS-2:0], si_s2_q};
      if (count_q == last_cnt) begin
        count_q <= 4'h0;
      end else begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  // completed character
  logic [BITS-1:0] char;
  assign char = {shift_q[BITS-2:0], si_s2_q};

  // data register: received char low, divider field high
  logic [BITS-1:0] rx_data_q;
  logic [6:0]      div_q;
  logic            rx_full_q;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rx_data_q <= '0;
    end else if (done_pulse) begin
      rx_data_q <= char;
    end
  end

  // divider bits are stored; slave reception ignores them
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      div_q <= `SRX_RST_DIV;
    end else if (wr_data) begin
      div_q <= i_wdata[`SRX_DIV_MSB:`SRX_DIV_LSB];
    end
  end

  // buffer full flag; a new char wins over a read
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rx_full_q <= 1'b0;
    end else if (done_pulse) begin
      rx_full_q <= 1'b1;
    end else if (rd_data) begin
      rx_full_q <= 1'b0;
    end
  end

  // error events from this channel and its async sibling
  logic [2:0] err_evt;
  assign err_evt[`SRX_ERR_FRM] = i_framing_err;
  assign err_evt[`SRX_ERR_PAR] = i_parity_err;
  assign err_evt[`SRX_ERR_OVR] = done_pulse & rx_full_q;

  // error flags survive a stop; write one clears, set wins
  logic [2:0] err_q;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      err_q <= 3'h0;
    end else if (wr_err) begin
      err_q <= (err_q & ~i_wdata[ERR_W-1:0]) | err_evt;
    end else begin
      err_q <= err_q | err_evt;
    end
  end

  // clock request to the clock generator while woken
  // drop beats set so a late clock edge cannot revive a request
  logic req_set;
  logic req_drop;
  assign req_set  = i_stop_mode & rx_allowed & sck_rise;
  assign req_drop = wake_clear | i_false_start |
                    (err_stop_q & (i_parity_err | i_framing_err)) |
                    ~i_stop_mode;
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_clock_request <= 1'b0;
    end else if (req_drop) begin
      o_clock_request <= 1'b0;
    end else if (req_set) begin
      o_clock_request <= 1'b1;
    end
  end

  // baud adjustment follows the wake bit
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_baud_adjust_en <= 1'b0;
    end else begin
      o_baud_adjust_en <= wake_en_q;
    end
  end

  // active status pin mirrors the status bit
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_active <= 1'b0;
    end else begin
      o_active <= active_q;
    end
  end

  // interrupt events: transfer end and gated channel error
  logic [1:0] irq_evt;
  assign irq_evt[`SRX_IRQ_DONE] = done_pulse;
  assign irq_evt[`SRX_IRQ_ERR]  = (|err_evt) & ~err_stop_q;

  // sticky interrupt status; an event beats a clear
  logic [1:0] istat_q;
  logic [1:0] ien_q;
  genvar gi;
  for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
    always_ff @(posedge i_clock or negedge rst_b_q) begin
      if (!rst_b_q) begin
        istat_q[gi] <= 1'b0;
      end else if (irq_evt[gi]) begin
        istat_q[gi] <= 1'b1;
      end else if (wr_iclr & i_wdata[gi]) begin
        istat_q[gi] <= 1'b0;
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      ien_q <= 2'h0;
    end else if (wr_ien) begin
      ien_q <= i_wdata[IRQ_W-1:0];
    end
  end

  // level interrupt from enabled status bits
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(istat_q & ien_q);
    end
  end

  // read mux; triggers and clear register read zero
  srx_word_t rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (i_addr)
      `SRX_A_STBY:  rd_mux = {14'h0000, err_stop_q, wake_en_q};
      `SRX_A_START: rd_mux = 16'h0000;
      `SRX_A_STOP:  rd_mux = 16'h0000;
      `SRX_A_STAT:  rd_mux = {12'h000, o_clock_request, rx_full_q,
                              state_q == SRX_RECV, active_q};
      `SRX_A_DATA:  rd_mux = {div_q, 9'(rx_data_q)};
      `SRX_A_ERR:   rd_mux = {13'h0000, err_q};
      `SRX_A_ISTAT: rd_mux = {14'h0000, istat_q};
      `SRX_A_IEN:   rd_mux = {14'h0000, ien_q};
      default:      rd_mux = 16'h0000;
    endcase
  end

  // read data stand in the cycle after the strobe only
  // an idle bus reads zero so a stale word never lingers
  always_ff @(posedge i_clock or negedge rst_b_q) begin
    if (!rst_b_q) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule : srx_channel

// [verif/srx_master.sv]
`timescale 1ns/1ns
module srx_master (
  output logic o_sck,
  output logic o_si
);
  // clock idles high between frames
  initial begin
    o_sck = 1'b1;
    o_si  = 1'b0;
  end
  // n bits msb first, one bit per 320 ns
  task automatic send(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      o_sck = 1'b0;
      o_si  = b[7-k];
      #160 o_sck = 1'b1;
      #160 o_si = ~o_si; // hold over, data no longer valid
    end
  endtask : send
endmodule : srx_master

// [verif/srx_sva.sv]
`timescale 1ns/1ns
`include "srx_regs.svh"
module srx_chk (
  input wire logic               i_clock,
  input wire logic               i_rst_b,
  input wire srx_pkg::srx_addr_t i_addr,
  input wire srx_pkg::srx_word_t i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire srx_pkg::srx_word_t o_rdata,
  input wire logic               i_false_start,
  input wire logic               i_parity_err,
  input wire logic               i_framing_err,
  input wire logic               o_clock_request,
  input wire logic               o_baud_adjust_en,
  input wire logic               o_active
);
  import srx_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic estop_q;
  // shadow of the error-stop bit
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) estop_q <= 1'b0;
    else if (i_wr && i_addr == `SRX_A_STBY)
      estop_q <= i_wdata[`SRX_STBY_ESTOP];
  end
  // trigger writes
  sequence s_trig;
    i_wr && (i_addr == `SRX_A_START || i_addr == `SRX_A_STOP);
  endsequence
  sequence s_start;
    i_wr && i_addr == `SRX_A_START && i_wdata[0];
  endsequence
  sequence s_stop;
    i_wr && i_addr == `SRX_A_STOP && i_wdata[0];
  endsequence
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  a_trig_zero: assert property (
    i_rd && (i_addr == `SRX_A_START || i_addr == `SRX_A_STOP)
    |=> o_rdata == 16'h0000)
    else $error("trigger read not zero");
  a_start_set: assert property (s_start |-> ##2 o_active)
    else $error("start did not set active");
  a_stop_clr: assert property (s_stop |-> ##2 !o_active)
    else $error("stop did not clear active");
  a_nop_trig: assert property (
    s_trig ##0 !i_wdata[0] |-> ##2 $stable(o_active))
    else $error("zero trigger changed state");
  a_baud_wake: assert property (
    i_wr && i_addr == `SRX_A_STBY |->
    ##2 o_baud_adjust_en == $past(i_wdata[0], 2))
    else $error("baud enable not wake bit");
  a_wake_drop: assert property (
    i_wr && i_addr == `SRX_A_STBY && !i_wdata[0] |->
    ##2 !o_clock_request)
    else $error("wake clear kept request");
  a_false_drop: assert property (
    i_false_start |=> !o_clock_request)
    else $error("false start kept request");
  a_err_drop: assert property (
    (i_parity_err || i_framing_err) && estop_q |=> !o_clock_request)
    else $error("error kept request");
endmodule : srx_chk
bind srx_channel srx_chk u_chk (.i_clock, .i_rst_b, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_false_start, .i_parity_err,
  .i_framing_err, .o_clock_request, .o_baud_adjust_en, .o_active);

// [verif/tb.sv]
`timescale 1ns/1ns
`include "srx_regs.svh"
module tb;
  import srx_pkg::*;
  logic       clk, rst_b, wr_s, rd_s, stop;
  logic       sck, si, req, baud, act, irq;
  logic [2:0] ev;
  srx_addr_t  addr;
  srx_word_t  wdata, rdata;
  int         miscompares, checks_done;
  srx_master m (.o_sck(sck), .o_si(si));
  srx_channel dut (.i_clock(clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_sck(sck), .i_si(si), .i_stop_mode(stop), .i_false_start(ev[0]),
    .i_parity_err(ev[1]), .i_framing_err(ev[2]), .o_clock_request(req),
    .o_baud_adjust_en(baud), .o_active(act), .o_irq(irq));
  // 25 mhz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input srx_word_t g, input srx_word_t e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input srx_addr_t a, input srx_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input srx_addr_t a, input srx_word_t e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse
  task automatic tx(input logic [7:0] b, input int n);
    @(negedge clk);
    m.send(b, n);
    wt(3);
  endtask : tx
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // hang guard
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end
  // main sequence
  initial begin
    {rst_b, wr_s, rd_s, stop, ev, addr, wdata} = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SRX_A_STBY, 16'h0000);
    rd(`SRX_A_START, 16'h0000);
    rd(8'h24, 16'h0000);
    wr(`SRX_A_DATA, 16'h0000);
    wr(`SRX_A_START, 16'h0000);
    rd(`SRX_A_STAT, 16'h0000);
    wr(`SRX_A_START, 16'h0001);
    rd(`SRX_A_STOP, 16'h0000);
    chk(16'(act), 16'h0001);
    wr(`SRX_A_STOP, 16'h0000);
    wt(1);
    chk(16'(act), 16'h0001);
    wr(`SRX_A_IEN, 16'h0003);
    tx(8'ha5, 8);
    rd(`SRX_A_ISTAT, 16'h0001);
    chk(16'(irq), 16'h0001);
    rd(`SRX_A_DATA, 16'h00a5);
    wr(`SRX_A_ICLR, 16'h0001);
    wt(2);
    chk(16'(irq), 16'h0000);
    // partial character survives a stop
    tx(8'h3c, 4);
    wr(`SRX_A_STOP, 16'h0001);
    wt(1);
    chk(16'(act), 16'h0000);
    tx(8'hff, 4);
    wr(`SRX_A_START, 16'h0001);
    tx(8'hc0, 4);
    rd(`SRX_A_ERR, 16'h0000);
    rd(`SRX_A_DATA, 16'h003c);
    // stop mode wake and clock request
    @(posedge clk) stop <= 1'b1;
    wr(`SRX_A_STBY, 16'h0000);
    tx(8'h0f, 8);
    chk(16'(req), 16'h0000);
    rd(`SRX_A_DATA, 16'h003c);
    wr(`SRX_A_STBY, 16'h0001);
    wt(1);
    chk(16'(baud), 16'h0001);
    tx(8'h80, 1);
    chk(16'(req), 16'h0001);
    pulse(3'h1);
    wt(1);
    chk(16'(req), 16'h0000);
    tx(8'h80, 1);
    wr(`SRX_A_STBY, 16'h0003);
    pulse(3'h2);
    wt(1);
    chk(16'(req), 16'h0000);
    rd(`SRX_A_ISTAT, 16'h0001);
    tx(8'h80, 1);
    wr(`SRX_A_STBY, 16'h0002);
    wt(1);
    chk(16'(req), 16'h0000);
    chk(16'(baud), 16'h0000);
    // error interrupt raised, then masked
    @(posedge clk) stop <= 1'b0;
    wr(`SRX_A_STBY, 16'h0000);
    pulse(3'h4);
    rd(`SRX_A_ISTAT, 16'h0003);
    chk(16'(irq), 16'h0001);
    wr(`SRX_A_IEN, 16'h0000);
    wt(1);
    chk(16'(irq), 16'h0000);
    summarize();
  end
endmodule : tb
